// ---- verilog/hrw_regs.vh ----
// Purpose: constants for the holding-register write and loopback handler
// Assumes: byte-wide frame interface, one clock
// Notes: definitions only
`ifndef HRW_REGS_VH
`define HRW_REGS_VH
`define HRW_FN_WRITE1 8'h06
`define HRW_FN_DIAG 8'h08
`define HRW_FN_WRITEN 8'h10
`define HRW_SUB_ECHO 16'h0000
`define HRW_BCAST_ADDR 8'h00
`define HRW_MAX_REGS 16'h007d
`define HRW_MIN_BYTES 8'h02
`define HRW_MAX_BYTES 8'hfa
`define HRW_CRC_INIT 16'hffff
`define HRW_CRC_POLY 16'ha001
`define HRW_BUF_BYTES 8
`endif

// ---- verilog/hrw_crc16.v ----
// Purpose: one-byte step of the reflected frame check
// Assumes: combinational, used per received or sent byte
// Notes: low bit first, polynomial from header
`include "hrw_regs.vh"
`default_nettype none
module hrw_crc16 (
	input wire [15:0] crcIn,
	input wire [7:0] dataIn,
	output reg [15:0] crcOut
);
	integer i;
	// eight shift steps with conditional polynomial xor
	always @* begin
		crcOut = crcIn ^ {8'h00, dataIn};
		for (i = 0; i < 8; i = i + 1) begin
			if (crcOut[0])
				crcOut = (crcOut >> 1) ^ `HRW_CRC_POLY;
			else
				crcOut = crcOut >> 1;
		end
	end
endmodule
`default_nettype wire

// ---- verilog/hrw_slave.v ----
// Purpose: slave handler for single write, loopback and multiple write queries
// Assumes: framer gives rxValid bytes and rxEnd after frame gap; txReady paces output
// Notes: single writes are applied only if the frame checks good; multiple writes are applied as data arrives, before the check
`include "hrw_regs.vh"
`default_nettype none
// What this block does
// R01: function 06 stores value in register
// R02: single value two bytes, high first
// R03: address field is register number minus 40001
// R04: address zero accepted for write functions
// R05: no reply to broadcast single write
// R06: write and loopback reply echo whole query
// R07: master waits processing time after broadcast
// R08: diagnosis 08 sub 00 echoes query
// R09: any loopback data value accepted
// R10: loopback needs nonzero slave address
// R11: function 10 writes consecutive registers
// R12: writing starts at the start address
// R13: register count at most 125
// R14: byte count twice count, 02 to FA
// R15: data high then low, ascending addresses
// R16: multiple write reply has no data
// R17: frames end with CRC, low byte first
module hrw_slave #(
	parameter [7:0] SLAVE_ADDR = 8'h01
) (
	input wire clk_sys,
	input wire rstn,
	input wire rxValid,
	input wire [7:0] rxByte,
	input wire rxEnd,
	input wire txReady,
	output reg txValid_ff,
	output reg [7:0] txByte_ff,
	output reg regWe_ff,
	output reg [15:0] regAddr_ff,
	output reg [15:0] regData_ff,
	output reg busy_ff
);
	localparam [1:0] ST_RX = 2'd0;
	localparam [1:0] ST_TX = 2'd1;
	localparam [1:0] ST_SKIP = 2'd2;
	reg [1:0] state_ff;
	// byte index, nine bits so a full 125-register frame does not wrap
	reg [8:0] cnt_ff;
	reg [7:0] buf_ff [0:`HRW_BUF_BYTES-1];
	reg [15:0] crc_ff;
	reg [15:0] wrPtr_ff;
	reg [15:0] hold_ff;
	reg [3:0] txIdx_ff;
	reg [3:0] txLen_ff;
	reg bad_ff;
	wire [15:0] crcNext;
	wire [15:0] txCrc;
	reg [7:0] txSel;
	wire [7:0] fn = buf_ff[1];
	wire [15:0] field1 = {buf_ff[2], buf_ff[3]};
	wire [15:0] field2 = {buf_ff[4], buf_ff[5]};
	wire isBcast = (buf_ff[0] == `HRW_BCAST_ADDR);
	wire isMultiFn = (fn == `HRW_FN_WRITEN);
	// end of multiple-write data and of its whole frame, in bytes
	wire [8:0] dataEnd = 9'h007 + {1'b0, buf_ff[6]};
	wire [8:0] frameEnd = dataEnd + 9'h002;
	integer k;

	// function codes served here; any other one spoils the frame
	function isKnownFn;
		input [7:0] code;
		begin
			isKnownFn = 1'b0;
			if (code == `HRW_FN_WRITE1)
				isKnownFn = 1'b1;
			else if (code == `HRW_FN_DIAG)
				isKnownFn = 1'b1;
			else if (code == `HRW_FN_WRITEN)
				isKnownFn = 1'b1;
		end
	endfunction

	hrw_crc16 uCrcRx (
		.crcIn(crc_ff),
		.dataIn(rxByte),
		.crcOut(crcNext)
	);

	// byte picked for transmit: buffered header byte at txIdx_ff; check bytes come from txCrc_ff
	always @* begin
		txSel = buf_ff[txIdx_ff[2:0]];
	end
	reg [15:0] txCrc_ff;
	hrw_crc16 uCrcTx (
		.crcIn(txCrc_ff),
		.dataIn(txSel),
		.crcOut(txCrc)
	);

	// receive, apply writes, then reply
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ST_RX;
			cnt_ff <= 9'h000;
			crc_ff <= `HRW_CRC_INIT;
			wrPtr_ff <= 16'h0000;
			hold_ff <= 16'h0000;
			txIdx_ff <= 4'h0;
			txLen_ff <= 4'h0;
			bad_ff <= 1'b0;
			txCrc_ff <= `HRW_CRC_INIT;
			txValid_ff <= 1'b0;
			txByte_ff <= 8'h00;
			regWe_ff <= 1'b0;
			regAddr_ff <= 16'h0000;
			regData_ff <= 16'h0000;
			busy_ff <= 1'b0;
			for (k = 0; k < `HRW_BUF_BYTES; k = k + 1)
				buf_ff[k] <= 8'h00;
		end else begin
			regWe_ff <= 1'b0;
			case (state_ff)
			ST_RX: begin
				if (rxValid) begin
					busy_ff <= 1'b1;
					// count saturates so an overlong frame never looks short
					if (cnt_ff != 9'h1ff)
						cnt_ff <= cnt_ff + 9'h001;
					crc_ff <= crcNext; // [R17]
					if (cnt_ff < `HRW_BUF_BYTES)
						buf_ff[cnt_ff[2:0]] <= rxByte;
					// unknown function code: ignore the frame
					if (cnt_ff == 9'h001 && !isKnownFn(rxByte))
						bad_ff <= 1'b1;
					// slave address: ours or broadcast, else ignore the frame
					if (cnt_ff == 9'h001 && buf_ff[0] != SLAVE_ADDR &&
						buf_ff[0] != `HRW_BCAST_ADDR)
						bad_ff <= 1'b1; // [R04]
					// multiple write header checks
					if (isMultiFn && cnt_ff == 9'h006) begin
						wrPtr_ff <= field1; // [R12] [R03]
						if (field2 == 16'h0000 || field2 > `HRW_MAX_REGS) // [R13]
							bad_ff <= 1'b1;
						if ({8'h00, rxByte} != {field2[14:0], 1'b0} ||
							rxByte < `HRW_MIN_BYTES || rxByte > `HRW_MAX_BYTES)
							bad_ff <= 1'b1; // [R14]
					end
					// register data: high byte then low, ascending; each write lands
					// as its low byte arrives, so a later bad check cannot undo it
					if (isMultiFn && cnt_ff >= 9'h007 && !bad_ff) begin
						if (cnt_ff[0])
							hold_ff[15:8] <= rxByte; // [R15]
						else if (cnt_ff < dataEnd) begin
							regWe_ff <= 1'b1; // [R11]
							regAddr_ff <= wrPtr_ff;
							regData_ff <= {hold_ff[15:8], rxByte};
							wrPtr_ff <= wrPtr_ff + 16'h0001;
						end
					end
				end
				if (rxEnd) begin
					cnt_ff <= 9'h000;
					crc_ff <= `HRW_CRC_INIT;
					bad_ff <= 1'b0;
					txIdx_ff <= 4'h0;
					txCrc_ff <= `HRW_CRC_INIT;
					state_ff <= ST_SKIP;
					busy_ff <= 1'b0;
					// good frame: check residue over every byte is zero
					if (!bad_ff && crc_ff == 16'h0000) begin
						if (fn == `HRW_FN_WRITE1 && cnt_ff == 9'h008) begin
							regWe_ff <= 1'b1; // [R01]
							regAddr_ff <= field1; // [R03]
							regData_ff <= field2; // [R02]
							// broadcast still writes but never answers
							if (!isBcast) begin // [R05]
								state_ff <= ST_TX;
								txLen_ff <= 4'h6; // [R06]
								busy_ff <= 1'b1;
							end
						end else if (fn == `HRW_FN_DIAG && cnt_ff == 9'h008 &&
							field1 == `HRW_SUB_ECHO && !isBcast) begin // [R10]
							state_ff <= ST_TX; // [R08] [R09]
							txLen_ff <= 4'h6;
							busy_ff <= 1'b1;
						end else if (isMultiFn && cnt_ff == frameEnd &&
							!isBcast) begin
							state_ff <= ST_TX; // [R16]
							txLen_ff <= 4'h6;
							busy_ff <= 1'b1;
						end
					end
				end
			end
			ST_TX: begin
				// first six bytes replayed, then crc low, high
				if (!txValid_ff || txReady) begin
					// header bytes out, check folded in as each one leaves
					if (txIdx_ff < txLen_ff) begin
						txValid_ff <= 1'b1;
						txByte_ff <= txSel;
						txCrc_ff <= txCrc;
						txIdx_ff <= txIdx_ff + 4'h1;
					end else if (txIdx_ff == txLen_ff) begin
						txValid_ff <= 1'b1;
						txByte_ff <= txCrc_ff[7:0]; // [R17]
						txIdx_ff <= txIdx_ff + 4'h1;
					end else if (txIdx_ff == txLen_ff + 4'h1) begin
						txValid_ff <= 1'b1;
						txByte_ff <= txCrc_ff[15:8];
						txIdx_ff <= txIdx_ff + 4'h1;
					end else begin
						// last byte taken: release the sink and listen again
						txValid_ff <= 1'b0;
						busy_ff <= 1'b0;
						state_ff <= ST_RX;
					end
				end
			end
			default: begin
				// one idle cycle between frames
				state_ff <= ST_RX;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- verification/hrw_slave_asserts.sv ----
// Purpose: hrw_slave port checks
// Assumes: rstn async low
// Notes: bound below
`default_nettype none
module hrw_slave_asserts (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic rxValid,
	input wire logic rxEnd,
	input wire logic txReady,
	input wire logic txValid_ff,
	input wire logic [7:0] txByte_ff,
	input wire logic regWe_ff,
	input wire logic busy_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// reply and write timing
	sequence s_stall; txValid_ff && !txReady; endsequence
	property p_hold; s_stall |=> txValid_ff && $stable(txByte_ff); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_src; regWe_ff |-> $past(rxEnd) || $past(rxValid); endproperty
	a_src: assert property (p_src) else $error("src");
	property p_one; regWe_ff |=> !regWe_ff; endproperty
	a_one: assert property (p_one) else $error("one");
	property p_noWe; txValid_ff |-> !regWe_ff; endproperty
	a_noWe: assert property (p_noWe) else $error("noWe");
	property p_txBusy; txValid_ff |-> busy_ff; endproperty
	a_txBusy: assert property (p_txBusy) else $error("txBusy");
	property p_rxBusy; rxValid |=> busy_ff; endproperty
	a_rxBusy: assert property (p_rxBusy) else $error("rxBusy");
	property p_skip; $rose(txValid_ff) |-> !$past(rxEnd); endproperty
	a_skip: assert property (p_skip) else $error("skip");
	property p_fell; $fell(busy_ff) |-> !txValid_ff; endproperty
	a_fell: assert property (p_fell) else $error("fell");
endmodule
bind hrw_slave hrw_slave_asserts u_chk (.clk_sys(clk_sys), .rstn(rstn), .rxValid(rxValid),
	.rxEnd(rxEnd), .txReady(txReady), .txValid_ff(txValid_ff), .txByte_ff(txByte_ff),
	.regWe_ff(regWe_ff), .busy_ff(busy_ff));
`default_nettype wire

// ---- verification/hrw_master_model.sv ----
// Purpose: reply sink
// Assumes: one clock
// Notes: slow stalls
`default_nettype none
module hrw_master_model (
	input wire logic clk_sys,
	input wire logic slow,
	input wire logic txValid_ff,
	input wire logic [7:0] txByte_ff,
	output var logic txReady
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got[$];
	logic tick_ff = 1'b0;
	// stall pattern off the edge
	always @(negedge clk_sys) begin
		tick_ff <= ~tick_ff;
		txReady <= !slow || tick_ff;
	end
	// take reply bytes
	always @(posedge clk_sys) if (txValid_ff && txReady) got.push_back(txByte_ff);
endmodule
`default_nettype wire

// ---- verification/hrw_slave_tb.sv ----
// Purpose: hrw_slave bench
// Assumes: 4 ns clock
// Notes: rows then multi write
`default_nettype none
module hrw_slave_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic [51:0] rows[8] = '{52'h0506000d1770_1, 52'h05080000ffff_1, 52'h0006ffff0001_2,
		52'h000800001234_0, 52'h050800011234_0, 52'h0506000155aa_3, 52'h0706000d1770_0,
		52'h0503000d0001_0};
	logic clk_sys = 1'b0, rstn = 1'b0, rxValid = 1'b0, rxEnd = 1'b0, slow = 1'b0;
	logic [7:0] rxByte = 8'h00, txByte_ff, q[$];
	logic txReady, txValid_ff, regWe_ff, busy_ff;
	logic [15:0] regAddr_ff, regData_ff;
	logic [31:0] wr[$];
	int fail_count = 0, checks_done = 0;
	// clock and write log
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (regWe_ff) wr.push_back({regAddr_ff, regData_ff});
	hrw_slave #(.SLAVE_ADDR(8'h05)) dut (.clk_sys(clk_sys), .rstn(rstn), .rxValid(rxValid),
		.rxByte(rxByte), .rxEnd(rxEnd), .txReady(txReady), .txValid_ff(txValid_ff),
		.txByte_ff(txByte_ff), .regWe_ff(regWe_ff), .regAddr_ff(regAddr_ff),
		.regData_ff(regData_ff), .busy_ff(busy_ff));
	hrw_master_model m (.clk_sys(clk_sys), .slow(slow), .txValid_ff(txValid_ff),
		.txByte_ff(txByte_ff), .txReady(txReady));
	task automatic chk(input string n, input logic [31:0] e, g);
		checks_done++;
		if (e !== g) begin
			fail_count++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic tally_and_finish(input int hung);
		fail_count += hung;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic addCrc(input logic [15:0] flip);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i]) begin
			c ^= {8'h00, q[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		c ^= flip;
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
	endtask
	task automatic send;
		m.got.delete();
		wr.delete();
		foreach (q[i]) begin
			@(negedge clk_sys) rxValid = 1'b1;
			rxByte = q[i];
		end
		@(negedge clk_sys) rxValid = 1'b0;
		rxEnd = 1'b1;
		@(negedge clk_sys) rxEnd = 1'b0;
		for (int i = 0; i < 99 && busy_ff !== 1'b0; i++) @(negedge clk_sys);
		if (busy_ff !== 1'b0) tally_and_finish(1);
		repeat (3) @(negedge clk_sys);
	endtask
	task automatic cmp;
		chk("len", q.size(), m.got.size());
		foreach (q[i]) chk("byte", q[i], m.got[i]);
	endtask
	// reset, table rows, then multiple write
	initial begin
		repeat (8) @(negedge clk_sys);
		chk("idle", 0, {txValid_ff, regWe_ff, busy_ff});
		rstn = 1'b1;
		foreach (rows[i]) begin
			q.delete();
			for (int j = 5; j >= 0; j--) q.push_back(rows[i][j*8+4 +: 8]);
			slow = 1'(i % 2);
			addCrc(16'(rows[i][3:0] == 3));
			send();
			if (rows[i][3:0] != 1) q.delete();
			cmp();
			chk("wn", rows[i][3:0] == 2 || rows[i][3:0] == 1 && q[1] == 8'h06, wr.size());
			if (wr.size() > 0) chk("wv", rows[i][35:4], wr[0]);
		end
		q = '{8'h05, 8'h10, 8'h00, 8'h20, 8'h00, 8'h02, 8'h04, 8'h12, 8'h34, 8'hab, 8'hcd};
		addCrc(16'h0000);
		send();
		chk("w0", 32'h00201234, wr[0]);
		chk("w1", 32'h0021abcd, wr[1]);
		q = q[0:5];
		addCrc(16'h0000);
		cmp();
		// broadcast multiple write: applied, never answered
		q = '{8'h00, 8'h10, 8'h00, 8'h40, 8'h00, 8'h01, 8'h02, 8'hbe, 8'hef};
		addCrc(16'h0000);
		send();
		chk("wbn", 1, wr.size());
		chk("wb", 32'h0040beef, wr[0]);
		chk("rb", 0, m.got.size());
		// byte count not twice the register count: refused whole
		q = '{8'h05, 8'h10, 8'h00, 8'h40, 8'h00, 8'h02, 8'h03, 8'h11, 8'h22, 8'h33};
		addCrc(16'h0000);
		send();
		chk("wbc", 0, wr.size() + m.got.size());
		// one register over the limit, then exactly at it
		q = '{8'h05, 8'h10, 8'h00, 8'h00, 8'h00, 8'h7e, 8'hfc};
		for (int j = 0; j < 252; j++) q.push_back(8'(j));
		addCrc(16'h0000);
		send();
		chk("wover", 0, wr.size() + m.got.size());
		q = '{8'h05, 8'h10, 8'h00, 8'h00, 8'h00, 8'h7d, 8'hfa};
		for (int j = 0; j < 250; j++) q.push_back(8'(j));
		addCrc(16'h0000);
		send();
		chk("wfull", 125, wr.size());
		chk("wlast", 32'h007cf8f9, wr[124]);
		q = q[0:5];
		addCrc(16'h0000);
		cmp();
		// reset in mid-frame, then a clean loopback must still echo
		q = '{8'h05, 8'h08, 8'h00};
		foreach (q[i]) begin
			@(negedge clk_sys) rxValid = 1'b1;
			rxByte = q[i];
		end
		@(negedge clk_sys) rxValid = 1'b0;
		rstn = 1'b0;
		@(negedge clk_sys) chk("rst", 0, {txValid_ff, regWe_ff, busy_ff});
		rstn = 1'b1;
		q = '{8'h05, 8'h08, 8'h00, 8'h00, 8'ha5, 8'h5a};
		addCrc(16'h0000);
		send();
		cmp();
		tally_and_finish(0);
	end
endmodule
`default_nettype wire
